// ==== hdl/asru_defs.svh ====
// Register offsets, field positions, reset values and tick counts of the serial unit
`ifndef ASRU_DEFS_SVH
`define ASRU_DEFS_SVH
`define ASRU_A_CTRL  8'h00
`define ASRU_A_BAUD  8'h04
`define ASRU_A_DATA  8'h08
`define ASRU_A_CTRL3 8'h0c
`define ASRU_A_STAT  8'h10
`define ASRU_A_IST   8'h14
`define ASRU_A_ICLR  8'h18
`define ASRU_A_IEN   8'h1c
`define ASRU_C_TXEN  0
`define ASRU_C_RXEN  1
`define ASRU_C_NINE  2
`define ASRU_C_TWOSB 3
`define ASRU_C_LOOP  4
`define ASRU_C_RECEIVER_SOURCE_SELECT  5
`define ASRU_C_EDGIE 6
`define ASRU_C3_T9   0
`define ASRU_C3_R9   1
`define ASRU_C3_DIR  2
`define ASRU_S_TX_BUFFER_EMPTY_FLAG  0
`define ASRU_S_TC    1
`define ASRU_S_RX_BUFFER_FULL_FLAG  2
`define ASRU_S_NF    3
`define ASRU_S_FE    4
`define ASRU_S_OR    5
`define ASRU_S_EDGE  6
`define ASRU_S_RAF   7
`define ASRU_CTRL_RST 7'h00
`define ASRU_BAUD_RST 13'h0001
`define ASRU_C3_RST   2'h0
`define ASRU_IEN_RST  7'h00
`define ASRU_RT_BIT   5'h10
`define ASRU_RT_S1    5'h08
`define ASRU_RT_S2    5'h09
`define ASRU_RT_S3    5'h0a
`define ASRU_LAST_MIN 4'h9
`endif

// ==== hdl/asru_pkg.sv ====
// Types shared by the serial unit
package asru_pkg;
	typedef enum logic {rx_idle, rx_frame} asru_rx_e;
	typedef logic [6:0] asru_ev_t;
endpackage

// ==== hdl/asru_top.sv ====
// Asynchronous serial transceiver with APB registers, loop and single-wire modes
`timescale 1ns/1ps
`include "asru_defs.svh"

// Operation
// R1: Stop bit is sampled at ticks 8, 9 and 10 and disagreement among those samples reports noise.
// R2: A majority of zero among the three stop-bit samples reports a framing error.
// R3: A falling edge inside a frame realigns the oversample counter unless it falls on sample ticks 8 to 10.
// R4: Each bit lasts 16 ticks and the last stop sample lands 154, 170 or 186 ticks after the start edge.
// R5: The nine-bit select sets both directions to nine data bits, the extra bit kept in its own fields.
// R6: The transmit ninth bit is copied with the data byte at each load and persists until rewritten.
// R7: Software writes the transmit ninth bit before the data register for a coherent character.
// R8: In stop all activity but the receive edge detector halts; retained stop keeps the other registers and resumes, other stops reset.
// R9: The receive edge detector stays active in retained stop and wakes the processor when enabled.
// R10: Software enters stop only with transmit complete, buffer empty and receiver idle.
// R11: With loop enabled, source select chooses internal loop at 0 and single-wire at 1.
// R12: Internal loop feeds the transmitter output straight into the receiver.
// R13: Single-wire joins receiver, transmitter and transmit pin, and releases the receive pin.
// R14: In single-wire, direction clear makes the pin an input, direction set drives it.
// R15: Any bit whose samples disagree sets the noise flag when the character is buffered.
// R16: While the framing error flag is set no new character enters the receive buffer.
// R17: The oversample tick comes from the bus clock through the baud divider at 16x the bit rate.
module asru_top (
	// Clock and reset
	input  wire logic        clk_sys,
	input  wire logic        reset_n,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// Serial pins
	input  wire logic        rxd_in,
	input  wire logic        txd_in,
	output logic             txd_out,
	output logic             txd_oe,
	output logic             rx_pin_released,
	// Power mode and interrupts
	input  wire logic        stop_req,
	input  wire logic        stop_retain,
	output logic             wake_req,
	output logic             irq
);
	logic [6:0]  ctrl_reg;
	logic [12:0] baud_reg;
	logic [1:0]  c3_reg;
	logic [6:0]  ien_reg;
	logic [6:0]  ist_reg;
	logic [12:0] div_reg;
	logic        txq_reg;
	asru_pkg::asru_rx_e rx_st_reg;
	logic [4:0]  rt_reg;
	logic [3:0]  bit_reg;
	logic        s1_reg, s2_reg, prev_reg, nacc_reg, facc_reg, resync_reg;
	logic [8:0]  sh_reg;
	logic [7:0]  fticks_reg;
	logic [7:0]  rx_data_reg;
	logic        rx_ninth_bit, rx_full_reg, edge_prev_reg;
	logic [7:0]  tx_buf_reg;
	logic        tx_empty_reg, tx_busy_reg;
	logic [11:0] tx_sh_reg;
	logic [3:0]  tx_rt_reg, tx_bit_reg;

	function automatic logic maj3(input logic a, input logic b, input logic c);
		return (a & b) | (a & c) | (b & c);
	endfunction

	logic hold, wipe, run, tick;
	logic nine_bit_mode, two_stop, internal_loopback_enable, receiver_source_select;
	logic single_wire_direction, tx_ninth_bit, sw_mode, lp_mode, rx_src;
	logic wr, rd, hit, fall, at10, rx_fin, maj, noisy, ferr, nerr, rx_load, tx_load, tx_done;
	logic [4:0] rt_nxt;
	logic [3:0] bit_nxt, last_bit;
	logic [3:0] nd_bit;
	logic [31:0] rd_val;
	logic [7:0] stat;
	asru_pkg::asru_ev_t ev, clr;

	assign hold = stop_req & stop_retain; // R8
	assign wipe = stop_req & ~stop_retain; // R8
	assign run = ~stop_req;
	assign nine_bit_mode = ctrl_reg[`ASRU_C_NINE];
	assign two_stop = ctrl_reg[`ASRU_C_TWOSB];
	assign internal_loopback_enable = ctrl_reg[`ASRU_C_LOOP];
	assign receiver_source_select = ctrl_reg[`ASRU_C_RECEIVER_SOURCE_SELECT];
	assign single_wire_direction = c3_reg[1];
	assign tx_ninth_bit = c3_reg[`ASRU_C3_T9];
	assign lp_mode = internal_loopback_enable & ~receiver_source_select; // R11
	assign sw_mode = internal_loopback_enable & receiver_source_select; // R11

	// Receiver input selection
	always_comb begin
		if (lp_mode)
			rx_src = txq_reg; // R12
		else if (sw_mode)
			rx_src = single_wire_direction ? txq_reg : txd_in; // R13 R14
		else
			rx_src = rxd_in;
	end

	// Oversample tick
	assign tick = run & (div_reg + 13'h0001 >= baud_reg); // R17
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n)
			div_reg <= 13'h0000;
		else if (wipe || tick)
			div_reg <= 13'h0000;
		else if (run)
			div_reg <= div_reg + 13'h0001; // R17
	end

	// APB access
	assign wr = run & psel & penable & pready & pwrite;
	assign rd = run & psel & penable & pready & ~pwrite;
	assign stat = {rx_st_reg == asru_pkg::rx_frame, ist_reg[6:3], rx_full_reg,
		~tx_busy_reg & tx_empty_reg, tx_empty_reg};
	always_comb begin
		hit = 1'b1;
		rd_val = 32'h0000_0000;
		case (paddr)
			`ASRU_A_CTRL:  rd_val[6:0] = ctrl_reg;
			`ASRU_A_BAUD:  rd_val[12:0] = baud_reg;
			`ASRU_A_DATA:  rd_val[8:0] = {rx_ninth_bit, rx_data_reg};
			`ASRU_A_CTRL3: rd_val[2:0] = {single_wire_direction, rx_ninth_bit, tx_ninth_bit};
			`ASRU_A_STAT:  rd_val[7:0] = stat;
			`ASRU_A_IST:   rd_val[6:0] = ist_reg;
			`ASRU_A_ICLR:  rd_val = 32'h0000_0000;
			`ASRU_A_IEN:   rd_val[6:0] = ien_reg;
			default:       hit = 1'b0;
		endcase
	end
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		end else if (wipe) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		end else begin
			pready <= run & psel & penable & ~pready;
			pslverr <= run & psel & penable & ~pready & ~hit;
			prdata <= rd_val;
		end
	end

	// Control registers
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			ctrl_reg <= `ASRU_CTRL_RST;
			baud_reg <= `ASRU_BAUD_RST;
			c3_reg <= `ASRU_C3_RST;
			ien_reg <= `ASRU_IEN_RST;
		end else if (wipe) begin
			ctrl_reg <= `ASRU_CTRL_RST;
			baud_reg <= `ASRU_BAUD_RST;
			c3_reg <= `ASRU_C3_RST;
			ien_reg <= `ASRU_IEN_RST;
		end else if (wr) begin
			if (paddr == `ASRU_A_CTRL)
				ctrl_reg <= pwdata[6:0];
			if (paddr == `ASRU_A_BAUD)
				baud_reg <= pwdata[12:0];
			if (paddr == `ASRU_A_CTRL3)
				c3_reg <= {pwdata[`ASRU_C3_DIR], pwdata[`ASRU_C3_T9]}; // R6
			if (paddr == `ASRU_A_IEN)
				ien_reg <= pwdata[6:0];
		end
	end

	// Receiver sampling
	assign rt_nxt = (rt_reg == `ASRU_RT_BIT) ? 5'h01 : rt_reg + 5'h01; // R4
	assign bit_nxt = (rt_reg == `ASRU_RT_BIT) ? bit_reg + 4'h1 : bit_reg;
	assign last_bit = `ASRU_LAST_MIN + {3'h0, nine_bit_mode} + {3'h0, two_stop}; // R4 R5
	assign nd_bit = nine_bit_mode ? 4'h9 : 4'h8; // R5
	assign fall = tick & prev_reg & ~rx_src;
	assign maj = maj3(s1_reg, s2_reg, rx_src); // R2
	assign noisy = ~((s1_reg == s2_reg) && (s2_reg == rx_src)); // R1 R15
	assign at10 = tick & (rx_st_reg == asru_pkg::rx_frame) & (rt_nxt == `ASRU_RT_S3);
	assign rx_fin = at10 & (bit_nxt == last_bit);
	assign ferr = facc_reg | ~maj; // R2
	assign nerr = nacc_reg | noisy; // R1 R15
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			rx_st_reg <= asru_pkg::rx_idle;
			rt_reg <= 5'h00;
			bit_reg <= 4'h0;
			s1_reg <= 1'b1;
			s2_reg <= 1'b1;
			prev_reg <= 1'b1;
			nacc_reg <= 1'b0;
			facc_reg <= 1'b0;
			resync_reg <= 1'b0;
			sh_reg <= 9'h000;
			fticks_reg <= 8'h00;
		end else if (wipe) begin
			rx_st_reg <= asru_pkg::rx_idle;
			rt_reg <= 5'h00;
			bit_reg <= 4'h0;
			s1_reg <= 1'b1;
			s2_reg <= 1'b1;
			prev_reg <= 1'b1;
			nacc_reg <= 1'b0;
			facc_reg <= 1'b0;
			resync_reg <= 1'b0;
			sh_reg <= 9'h000;
			fticks_reg <= 8'h00;
		end else if (tick) begin
			prev_reg <= rx_src;
			case (rx_st_reg)
				asru_pkg::rx_idle: begin
					if (fall && ctrl_reg[`ASRU_C_RXEN]) begin
						rx_st_reg <= asru_pkg::rx_frame;
						rt_reg <= 5'h01;
						bit_reg <= 4'h0;
						nacc_reg <= 1'b0;
						facc_reg <= 1'b0;
						resync_reg <= 1'b0;
						fticks_reg <= 8'h01;
					end
				end
				asru_pkg::rx_frame: begin
					fticks_reg <= fticks_reg + 8'h01;
					rt_reg <= rt_nxt;
					bit_reg <= bit_nxt;
					if (fall && rt_nxt > 5'h01 && rt_nxt < `ASRU_RT_S1) begin
						rt_reg <= 5'h01; // R3
						resync_reg <= 1'b1;
					end else if (fall && rt_nxt > `ASRU_RT_S3 && bit_nxt < last_bit) begin
						rt_reg <= 5'h01; // R3
						bit_reg <= bit_nxt + 4'h1;
						resync_reg <= 1'b1;
					end
					if (rt_nxt == `ASRU_RT_S1)
						s1_reg <= rx_src; // R1
					if (rt_nxt == `ASRU_RT_S2)
						s2_reg <= rx_src; // R1
					if (at10) begin
						nacc_reg <= nerr; // R15
						if (bit_nxt == 4'h0 && maj)
							rx_st_reg <= asru_pkg::rx_idle;
						else if (bit_nxt != 4'h0 && bit_nxt <= nd_bit)
							sh_reg <= {maj, sh_reg[8:1]};
						else if (bit_nxt != 4'h0)
							facc_reg <= ferr; // R2
						if (rx_fin)
							rx_st_reg <= asru_pkg::rx_idle;
					end
				end
				default: rx_st_reg <= asru_pkg::rx_idle;
			endcase
		end
	end

	// Receive buffer
	assign rx_load = rx_fin & ~ist_reg[`ASRU_S_FE] & ~rx_full_reg; // R16
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			rx_data_reg <= 8'h00;
			rx_ninth_bit <= 1'b0;
			rx_full_reg <= 1'b0;
		end else if (wipe) begin
			rx_data_reg <= 8'h00;
			rx_ninth_bit <= 1'b0;
			rx_full_reg <= 1'b0;
		end else begin
			if (rd && paddr == `ASRU_A_DATA)
				rx_full_reg <= 1'b0;
			if (rx_load) begin
				rx_full_reg <= 1'b1;
				rx_data_reg <= nine_bit_mode ? sh_reg[7:0] : sh_reg[8:1]; // R5
				rx_ninth_bit <= nine_bit_mode & sh_reg[8]; // R5
			end
		end
	end

	// Transmitter
	assign tx_load = run & ~tx_busy_reg & ~tx_empty_reg & ctrl_reg[`ASRU_C_TXEN];
	assign tx_done = tick & tx_busy_reg & (tx_rt_reg == 4'hf) & (tx_bit_reg == last_bit);
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			tx_buf_reg <= 8'h00;
			tx_empty_reg <= 1'b1;
			tx_busy_reg <= 1'b0;
			tx_sh_reg <= 12'hfff;
			tx_rt_reg <= 4'h0;
			tx_bit_reg <= 4'h0;
			txq_reg <= 1'b1;
		end else if (wipe) begin
			tx_buf_reg <= 8'h00;
			tx_empty_reg <= 1'b1;
			tx_busy_reg <= 1'b0;
			tx_sh_reg <= 12'hfff;
			tx_rt_reg <= 4'h0;
			tx_bit_reg <= 4'h0;
			txq_reg <= 1'b1;
		end else if (run) begin
			txq_reg <= tx_busy_reg ? tx_sh_reg[0] : 1'b1;
			if (tx_load) begin
				tx_empty_reg <= 1'b1;
				tx_busy_reg <= 1'b1;
				tx_rt_reg <= 4'h0;
				tx_bit_reg <= 4'h0;
				if (nine_bit_mode)
					tx_sh_reg <= {2'h3, tx_ninth_bit, tx_buf_reg, 1'b0}; // R5 R6 R7
				else
					tx_sh_reg <= {3'h7, tx_buf_reg, 1'b0};
			end else if (tick && tx_busy_reg) begin
				tx_rt_reg <= tx_rt_reg + 4'h1;
				if (tx_rt_reg == 4'hf) begin
					tx_sh_reg <= {1'b1, tx_sh_reg[11:1]};
					tx_bit_reg <= tx_bit_reg + 4'h1;
					if (tx_done)
						tx_busy_reg <= 1'b0;
				end
			end
			if (wr && paddr == `ASRU_A_DATA) begin
				tx_buf_reg <= pwdata[7:0];
				tx_empty_reg <= 1'b0;
			end
		end
	end

	// Events, interrupt status and edge wake-up
	always_comb begin
		ev = 7'h00;
		ev[`ASRU_S_TX_BUFFER_EMPTY_FLAG] = tx_load;
		ev[`ASRU_S_TC] = tx_done & tx_empty_reg;
		ev[`ASRU_S_RX_BUFFER_FULL_FLAG] = rx_load;
		ev[`ASRU_S_NF] = rx_load & nerr; // R1 R15
		ev[`ASRU_S_FE] = rx_load & ferr; // R2
		ev[`ASRU_S_OR] = rx_fin & ~ist_reg[`ASRU_S_FE] & rx_full_reg;
		ev[`ASRU_S_EDGE] = edge_prev_reg & ~rx_src & ctrl_reg[`ASRU_C_RXEN]; // R9
		clr = (wr && paddr == `ASRU_A_ICLR) ? pwdata[6:0] : 7'h00;
	end
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			ist_reg <= 7'h00;
			edge_prev_reg <= 1'b1;
			wake_req <= 1'b0;
			irq <= 1'b0;
		end else if (wipe) begin
			ist_reg <= 7'h00;
			edge_prev_reg <= 1'b1;
			wake_req <= 1'b0;
			irq <= 1'b0;
		end else begin
			edge_prev_reg <= rx_src; // R9
			ist_reg <= (ist_reg & ~clr) | ev;
			wake_req <= hold & ev[`ASRU_S_EDGE] & ctrl_reg[`ASRU_C_EDGIE]; // R9
			irq <= |(((ist_reg & ~clr) | ev) & ien_reg);
		end
	end

	// Pin direction
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			txd_oe <= 1'b1;
			rx_pin_released <= 1'b0;
		end else if (!hold) begin
			txd_oe <= ~(sw_mode & ~single_wire_direction); // R14
			rx_pin_released <= sw_mode; // R13
		end
	end
	assign txd_out = txq_reg;

	default clocking dcb @(posedge clk_sys); endclocking
	default disable iff (!reset_n);

	sequence good_fin_s;
		rx_fin && !ist_reg[`ASRU_S_FE] && !rx_full_reg && !wipe;
	endsequence
	sequence retained_s;
		hold ##1 hold;
	endsequence

	stop_noise_a: assert property (good_fin_s and (s1_reg != s2_reg) |=> ist_reg[`ASRU_S_NF]) // R1
		else $error("stop sample mismatch did not flag noise");
	stop_frame_a: assert property (good_fin_s and (!s1_reg && !s2_reg) |=> ist_reg[`ASRU_S_FE]) // R2
		else $error("zero stop majority did not flag framing");
	edge_resync_a: assert property (fall && rx_st_reg == asru_pkg::rx_frame && rt_nxt > 5'h01 && rt_nxt < 5'h08
		&& !wipe |=> rt_reg == 5'h01) // R3
		else $error("edge inside frame did not realign");
	frame_len_a: assert property (rx_fin && !resync_reg |-> fticks_reg + 8'h01 == {last_bit, 4'h0} + 8'h0a) // R4
		else $error("stop sampling at wrong tick");
	ninth_copy_a: assert property (tx_load && nine_bit_mode && !wipe |=> tx_sh_reg[9] == $past(tx_ninth_bit)) // R6
		else $error("ninth bit not copied at load");
	stop_hold_a: assert property (retained_s |-> $stable(rt_reg) && $stable(tx_sh_reg) && $stable(ctrl_reg)) // R8
		else $error("state changed in retained stop");
	edge_wake_a: assert property (hold && ev[`ASRU_S_EDGE] && ctrl_reg[`ASRU_C_EDGIE] |=> wake_req) // R9
		else $error("edge in stop did not wake");
	loop_feed_a: assert property (lp_mode |-> rx_src == txq_reg) // R11 R12
		else $error("loop mode not fed from transmitter");
	wire_dir_a: assert property (sw_mode && !single_wire_direction && !hold && !wipe |=> !txd_oe) // R14
		else $error("single-wire input still driven");
	fe_block_a: assert property (rx_fin && ist_reg[`ASRU_S_FE] && !rx_full_reg && !wipe |=> !rx_full_reg) // R16
		else $error("character loaded under framing error");
	tick_rate_a: assert property (tick && baud_reg == 13'h0003 ##1 (!stop_req && baud_reg == 13'h0003) [*3] |-> // R17
		tick && !$past(tick, 1) && !$past(tick, 2))
		else $error("tick spacing not the divider value");
endmodule

// ==== verif/asru_peer.sv ====
// Remote serial device model: frame sender and frame receiver
`timescale 1ns/1ps
module asru_peer (
	// Clock
	input  wire logic clk_sys,
	// Serial lines
	input  wire logic line_in,
	output logic      line_out
);
	initial line_out = 1'b1;

	// Start, nb data bits LSB first, stop level st; gl inverts the line for one clock
	task automatic send(input logic [8:0] d, input int nb, input int bc, input int gl, input logic st);
		logic [10:0] fr;
		fr = {1'b1, d, 1'b0};
		fr[nb + 1] = st;
		for (int i = 0; i < (nb + 2) * bc; i++) begin
			@(posedge clk_sys);
			line_out <= fr[i / bc] ^ (i == gl);
		end
		@(posedge clk_sys);
		line_out <= 1'b1;
	endtask

	// Samples each data bit in its middle; all zeros when no start bit shows up
	task automatic recv(input int nb, input int bc, output logic [8:0] d);
		int n;
		n = 0;
		d = 9'h000;
		while (line_in !== 1'b0 && n < 4000) begin
			@(posedge clk_sys);
			n++;
		end
		if (n < 4000) begin
			repeat (bc / 2) @(posedge clk_sys);
			for (int i = 0; i < nb; i++) begin
				repeat (bc) @(posedge clk_sys);
				d[i] = line_in;
			end
		end
	endtask
endmodule

// ==== verif/async_serial_rx_tx_options_tb.sv ====
// Self-checking bench for the serial unit
`timescale 1ns/1ps
`include "asru_defs.svh"
module async_serial_rx_tx_options_tb;
	logic        clk_sys     = 1'b0;
	logic        reset_n     = 1'b0;
	logic        psel        = 1'b0;
	logic        penable     = 1'b0;
	logic        pwrite      = 1'b0;
	logic [7:0]  paddr       = 8'h00;
	logic [31:0] pwdata      = 32'h0;
	logic        stop_req    = 1'b0;
	logic        stop_retain = 1'b0;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        txd_out;
	logic        txd_oe;
	logic        rx_pin_released;
	logic        wake_req;
	logic        irq;
	wire logic   peer_line;
	wire logic   txd_wire;
	logic [31:0] rd;
	logic        er;
	int          fails       = 0;
	int          n_compared  = 0;

	always #2 clk_sys = ~clk_sys;
	// Transmit pin level: unit drives when enabled, else the far device
	assign txd_wire = txd_oe ? txd_out : peer_line;

	asru_top dut (.clk_sys(clk_sys), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.rxd_in(peer_line), .txd_in(txd_wire), .txd_out(txd_out), .txd_oe(txd_oe),
		.rx_pin_released(rx_pin_released), .stop_req(stop_req), .stop_retain(stop_retain),
		.wake_req(wake_req), .irq(irq));
	asru_peer peer (.clk_sys(clk_sys), .line_in(txd_wire), .line_out(peer_line));

	task conclude;
		$display("compared %0d mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			fails++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask

	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk_sys);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		do begin
			@(posedge clk_sys);
			n++;
		end while (pready !== 1'b1 && n < 50);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 50) begin
			fails++;
			conclude;
		end
	endtask

	// Far device sends one 8-bit frame, then status flags and data are read back
	task rxf(input logic [8:0] d, input int bc, input int gl, input logic st, input logic [31:0] ed,
		input logic [31:0] es);
		peer.send(d, 8, bc, gl, st);
		repeat (20) @(posedge clk_sys);
		apb(1'b0, `ASRU_A_STAT, 32'h0);
		chk("rx flags", es, rd & 32'h3c);
		apb(1'b0, `ASRU_A_DATA, 32'h0);
		chk("rx data", ed, rd);
	endtask

	task t_regs;
		apb(1'b0, `ASRU_A_CTRL, 32'h0);
		chk("ctrl reset", 32'h0, rd);
		apb(1'b0, `ASRU_A_BAUD, 32'h0);
		chk("baud reset", 32'h1, rd);
		apb(1'b0, 8'h20, 32'h0);
		chk("unmapped err", 32'h1, {31'h0, er});
		chk("unmapped data", 32'h0, rd);
		$display("test regs done");
	endtask

	task t_tx;
		logic [8:0] v;
		apb(1'b1, `ASRU_A_BAUD, 32'h2);
		apb(1'b1, `ASRU_A_CTRL, 32'h3);
		apb(1'b1, `ASRU_A_DATA, 32'ha5);
		peer.recv(8, 32, v);
		chk("tx byte", 32'ha5, {23'h0, v});
		repeat (80) @(posedge clk_sys);
		apb(1'b0, `ASRU_A_STAT, 32'h0);
		chk("tx idle", 32'h3, rd & 32'h83);
		apb(1'b1, `ASRU_A_BAUD, 32'h1);
		$display("test tx done");
	endtask

	task t_rx;
		rxf(9'h055, 17, -1, 1'b1, 32'h55, 32'h04);
		apb(1'b1, `ASRU_A_ICLR, 32'h7f);
		// Fast far device: edges late in a bit start the next one early
		rxf(9'h055, 15, -1, 1'b1, 32'h55, 32'h04);
		apb(1'b1, `ASRU_A_ICLR, 32'h7f);
		rxf(9'h03c, 16, 152, 1'b1, 32'h3c, 32'h0c);
		apb(1'b1, `ASRU_A_ICLR, 32'h7f);
		rxf(9'h0c3, 16, 72, 1'b1, 32'hc3, 32'h0c);
		apb(1'b1, `ASRU_A_ICLR, 32'h7f);
		$display("test rx done");
	endtask

	task t_fe;
		apb(1'b1, `ASRU_A_IEN, 32'h04);
		rxf(9'h081, 16, -1, 1'b0, 32'h81, 32'h14);
		apb(1'b1, `ASRU_A_ICLR, 32'h04);
		repeat (3) @(posedge clk_sys);
		chk("irq cleared", 32'h0, {31'h0, irq});
		rxf(9'h011, 16, -1, 1'b1, 32'h81, 32'h10);
		chk("irq refused", 32'h0, {31'h0, irq});
		apb(1'b1, `ASRU_A_ICLR, 32'h10);
		apb(1'b1, `ASRU_A_IEN, 32'h0);
		rxf(9'h022, 16, -1, 1'b1, 32'h22, 32'h04);
		chk("irq masked", 32'h0, {31'h0, irq});
		apb(1'b1, `ASRU_A_IEN, 32'h04);
		repeat (3) @(posedge clk_sys);
		chk("irq raised", 32'h1, {31'h0, irq});
		apb(1'b1, `ASRU_A_ICLR, 32'h7f);
		repeat (3) @(posedge clk_sys);
		chk("irq low", 32'h0, {31'h0, irq});
		$display("test framing done");
	endtask

	task t_nine;
		logic [8:0] ex [3];
		ex = '{9'h15a, 9'h10f, 9'h00f};
		// Nine data bits with two stop bits over the internal loop
		apb(1'b1, `ASRU_A_CTRL, 32'h1f);
		for (int i = 0; i < 3; i++) begin
			// Ninth bit written first; the middle character reuses it
			if (i != 1) begin
				apb(1'b1, `ASRU_A_CTRL3, {31'h0, i == 0});
			end
			apb(1'b1, `ASRU_A_DATA, {24'h0, ex[i][7:0]});
			repeat (240) @(posedge clk_sys);
			apb(1'b0, `ASRU_A_DATA, 32'h0);
			chk("loop char", {23'h0, ex[i]}, rd);
		end
		$display("test nine done");
	endtask

	task t_sw;
		apb(1'b1, `ASRU_A_CTRL, 32'h33);
		apb(1'b1, `ASRU_A_CTRL3, 32'h0);
		repeat (3) @(posedge clk_sys);
		chk("pin input", 32'h0, {31'h0, txd_oe});
		chk("rx pin free", 32'h1, {31'h0, rx_pin_released});
		rxf(9'h06b, 16, -1, 1'b1, 32'h6b, 32'h04);
		apb(1'b1, `ASRU_A_CTRL3, 32'h4);
		repeat (3) @(posedge clk_sys);
		chk("pin driven", 32'h1, {31'h0, txd_oe});
		apb(1'b1, `ASRU_A_DATA, 32'h3c);
		repeat (220) @(posedge clk_sys);
		apb(1'b0, `ASRU_A_DATA, 32'h0);
		chk("own char", 32'h3c, rd);
		$display("test single wire done");
	endtask

	task t_stop;
		int n;
		n = 0;
		apb(1'b1, `ASRU_A_CTRL, 32'h43);
		apb(1'b1, `ASRU_A_BAUD, 32'h3);
		apb(1'b0, `ASRU_A_STAT, 32'h0);
		chk("stop ready", 32'h3, rd & 32'h83);
		stop_retain <= 1'b1;
		stop_req <= 1'b1;
		fork
			peer.send(9'h000, 8, 16, -1, 1'b1);
			while (wake_req !== 1'b1 && n < 200) begin
				@(posedge clk_sys);
				n++;
			end
		join
		chk("wake", 32'h1, {31'h0, n < 200});
		if (n >= 200) begin
			conclude;
		end
		stop_req <= 1'b0;
		apb(1'b0, `ASRU_A_BAUD, 32'h0);
		chk("baud kept", 32'h3, rd);
		stop_retain <= 1'b0;
		stop_req <= 1'b1;
		repeat (3) @(posedge clk_sys);
		stop_req <= 1'b0;
		apb(1'b0, `ASRU_A_BAUD, 32'h0);
		chk("baud wiped", 32'h1, rd);
		apb(1'b0, `ASRU_A_CTRL, 32'h0);
		chk("ctrl wiped", 32'h0, rd);
		$display("test stop done");
	endtask

	initial begin
		repeat (100000) @(posedge clk_sys);
		fails++;
		conclude;
	end

	initial begin
		repeat (5) @(posedge clk_sys);
		reset_n <= 1'b1;
		t_regs;
		t_tx;
		t_rx;
		t_fe;
		t_nine;
		t_sw;
		t_stop;
		conclude;
	end
endmodule
